// File: src/addr_wrap_cfg.svh
/*
  Constants for the effective-address range and wrap logic.
  Assumes inclusion by bare name from the modules; the package does not include it.
*/
`ifndef ADDR_WRAP_CFG_SVH
`define ADDR_WRAP_CFG_SVH
`define STACK_PAGE_HIGH 8'h01
`define BANK_ZERO 8'h00
`define ZERO_BYTE 8'h00
`define ZERO_ADDR 24'h00_0000
`define ADDR_VARIANT_WIDE 1'b1
`define STACK_RESET_VAL 16'h01FF
`define EMU_RESET_VAL 1'b1
`define STACK_STEP 16'h0001
`endif

// File: src/addr_wrap_pkg.sv
/*
  Types for the effective-address range and wrap logic.
  Assumes the _cfg header for constants; holds types only.
*/
package addr_wrap_pkg;
  typedef enum logic [3:0] {
    mode_stack,
    mode_stack_multi,
    mode_stack_relative,
    mode_direct,
    mode_direct_long_ptr,
    mode_absolute_indexed,
    mode_long
  } addr_mode_e;

  typedef struct packed {
    addr_mode_e mode;
    logic [7:0] bank;
    logic [15:0] base;
    logic [15:0] offset;
  } addr_req_s;

  typedef struct packed {
    logic [23:0] addr;
    logic [15:0] stack_ptr;
    logic emu;
  } wrap_state_s;
endpackage : addr_wrap_pkg

// File: src/direct_page_wrap.sv
/*
  Direct-page address former for emulation and native modes.
  Assumes the direct register and offset come from the same clock domain.
*/
`timescale 1ns/100ps
`include "addr_wrap_cfg.svh"
module direct_page_wrap
  import addr_wrap_pkg::*;
(
  input wire logic emu,
  input wire logic long_ptr,
  input wire logic [15:0] direct_reg,
  input wire logic [15:0] offset,
  output logic [15:0] addr
);
  logic [15:0] full_sum;
  logic low_byte_zero;

  always_comb begin
    full_sum = direct_reg + offset;
    low_byte_zero = (direct_reg[7:0] == `ZERO_BYTE);
    if (!emu) begin
      addr = full_sum;
    end else if (!low_byte_zero) begin
      addr = full_sum;
    end else if (long_ptr) begin
      // Pointer bytes step past the page end into the next page
      addr = full_sum;
    end else begin
      addr = {direct_reg[15:8], offset[7:0]};
    end
  end
endmodule : direct_page_wrap

// File: src/addr_range_wrap.sv
/*
  Effective-address range and wrap logic of the core.
  Assumes requests arrive from the core's address adders on clk; address is registered once.
*/
`timescale 1ns/100ps
`include "addr_wrap_cfg.svh"
// Operation
// - In native mode the stack pointer and every stack-type address stay in bank zero.
// - In emulation mode the stack sits in page one of bank zero.
// - In emulation mode multi-byte stack accesses may step past page one.
// - In native mode direct and direct-indexed addresses are 16-bit in bank zero.
// - Emulation with zero direct register wraps in page zero, long pointers carry on.
// - Emulation with zero low byte wraps in the direct page, long pointers carry on.
// - Emulation with nonzero low byte uses the full bank-zero range.
// - The 16-bit variant wraps absolute indexed sums within 64K.
// - The 24-bit variant carries the indexed sum into the bank byte.
// - Stack-relative addresses take stack plus offset with bank forced to zero.
// - Entering emulation forces the stack high byte to 01.
module addr_range_wrap
  import addr_wrap_pkg::*;
#(
  parameter bit WIDE_ADDR = `ADDR_VARIANT_WIDE
)(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic emu_flag,
  input wire logic [15:0] direct_reg,
  input wire logic stack_load,
  input wire logic [15:0] stack_load_val,
  input wire logic stack_step,
  input wire logic stack_down,
  input wire addr_req_s req,
  output logic [23:0] mem_addr,
  output logic [15:0] stack_ptr,
  output logic emu_mode
);
  wrap_state_s st_q;
  wrap_state_s st_d;
  logic [15:0] dp_addr;
  logic dp_long_ptr;
  logic [15:0] sp_next;
  logic [23:0] addr_next;

  function automatic logic [15:0] stack_fix(input logic emu, input logic [15:0] sp);
    stack_fix = emu ? {`STACK_PAGE_HIGH, sp[7:0]} : sp;
  endfunction : stack_fix

  // One-step move; the page-one clamp is applied by the caller
  function automatic logic [15:0] stack_move(
    input logic [15:0] sp,
    input logic down
  );
    logic [15:0] moved;
    moved = sp;
    if (down) begin
      moved = sp - `STACK_STEP;
    end else begin
      moved = sp + `STACK_STEP;
    end
    stack_move = moved;
  endfunction : stack_move

  // A load wins over a step in the same cycle
  function automatic logic [15:0] next_stack(
    input logic emu,
    input logic [15:0] cur,
    input logic load,
    input logic [15:0] load_val,
    input logic step,
    input logic down
  );
    logic [15:0] sp_cur;
    logic [15:0] sp_new;
    // Page one is enforced on every cycle while in emulation, not only at entry
    sp_cur = stack_fix(emu, cur);
    sp_new = sp_cur;
    if (load) begin
      sp_new = load_val;
    end else if (step) begin
      sp_new = stack_move(sp_cur, down);
    end
    next_stack = stack_fix(emu, sp_new);
  endfunction : next_stack

  function automatic logic [16:0] wide_sum(
    input logic [15:0] base,
    input logic [15:0] offset
  );
    wide_sum = {1'b0, base} + {1'b0, offset};
  endfunction : wide_sum

  function automatic logic [23:0] bank_zero_addr(input logic [15:0] low);
    bank_zero_addr = {`BANK_ZERO, low};
  endfunction : bank_zero_addr

  // Narrow variant drops the carry, so page FF indexing folds back to page 00
  function automatic logic [23:0] indexed_addr(
    input logic wide,
    input logic [7:0] bank,
    input logic [16:0] sum
  );
    logic [7:0] bank_out;
    bank_out = `BANK_ZERO;
    if (wide) begin
      bank_out = bank + {7'h00, sum[16]};
    end
    indexed_addr = {bank_out, sum[15:0]};
  endfunction : indexed_addr

  // Long addressing carries across banks with no guard
  function automatic logic [23:0] long_addr(
    input logic [7:0] bank,
    input logic [15:0] base,
    input logic [15:0] offset
  );
    long_addr = {bank, base} + {`BANK_ZERO, offset};
  endfunction : long_addr

  // In emulation with a zero direct low byte, only the long-pointer direct mode may carry out of its page
  function automatic logic is_long_ptr(input addr_mode_e mode);
    is_long_ptr = (mode == mode_direct_long_ptr);
  endfunction : is_long_ptr

  // Modes whose result never leaves bank zero
  function automatic logic bank_zero_mode(input addr_mode_e mode);
    logic hit;
    hit = 1'b0;
    case (mode)
      mode_stack, mode_stack_multi, mode_stack_relative: begin
        hit = 1'b1;
      end
      mode_direct, mode_direct_long_ptr: begin
        hit = 1'b1;
      end
      default: begin
        hit = 1'b0;
      end
    endcase
    bank_zero_mode = hit;
  endfunction : bank_zero_mode

  // Effective address of one request, before the bank-zero guard
  function automatic logic [23:0] form_addr(
    input addr_mode_e mode,
    input logic emu,
    input logic wide,
    input logic [7:0] bank,
    input logic [15:0] base,
    input logic [15:0] offset,
    input logic [15:0] dp
  );
    logic [16:0] sum;
    logic [23:0] addr;
    sum = wide_sum(base, offset);
    addr = `ZERO_ADDR;
    case (mode)
      mode_stack: begin
        addr = bank_zero_addr(stack_fix(emu, base));
      end
      mode_stack_multi: begin
        // Full 16-bit step allowed past page one for two- and three-byte pushes
        addr = bank_zero_addr(sum[15:0]);
      end
      mode_stack_relative: begin
        addr = bank_zero_addr(sum[15:0]);
      end
      mode_direct, mode_direct_long_ptr: begin
        addr = bank_zero_addr(dp);
      end
      mode_absolute_indexed: begin
        addr = indexed_addr(wide, bank, sum);
      end
      mode_long: begin
        addr = long_addr(bank, base, offset);
      end
      default: begin
        addr = `ZERO_ADDR;
      end
    endcase
    form_addr = addr;
  endfunction : form_addr

  assign dp_long_ptr = is_long_ptr(req.mode);

  // Direct-page forming sits apart so its wrap cases stand alone
  direct_page_wrap u_dp (
    .emu(emu_flag),
    .long_ptr(dp_long_ptr),
    .direct_reg(direct_reg),
    .offset(req.offset),
    .addr(dp_addr)
  );

  always_comb begin
    st_d = st_q;
    st_d.emu = emu_flag;
    sp_next = next_stack(emu_flag, st_q.stack_ptr, stack_load, stack_load_val,
      stack_step, stack_down);
    addr_next = form_addr(req.mode, emu_flag, WIDE_ADDR, req.bank, req.base,
      req.offset, dp_addr);
    st_d.stack_ptr = sp_next;
    // Guard holds stack and direct results in bank zero whatever the adders give
    if (bank_zero_mode(req.mode)) begin
      st_d.addr = {`BANK_ZERO, addr_next[15:0]};
    end else begin
      st_d.addr = addr_next;
    end
  end

  // One register stage: address and stack settle one edge after the request
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= '{addr: `ZERO_ADDR, stack_ptr: `STACK_RESET_VAL, emu: `EMU_RESET_VAL};
    end else begin
      st_q <= st_d;
    end
  end

  // Outputs come straight from the state register
  assign mem_addr = st_q.addr;
  assign stack_ptr = st_q.stack_ptr;
  assign emu_mode = st_q.emu;
endmodule : addr_range_wrap

// File: verif/addr_range_wrap_props.sv
/* Checker on addr_range_wrap ports; assumes the bind at the foot. */
`timescale 1ns/100ps
`include "addr_wrap_cfg.svh"
module addr_range_wrap_props
  import addr_wrap_pkg::*;
#(
  parameter bit WIDE_ADDR = `ADDR_VARIANT_WIDE
)(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic emu_flag,
  input wire logic [15:0] direct_reg,
  input wire logic stack_load,
  input wire logic [15:0] stack_load_val,
  input wire addr_req_s req,
  input wire logic [23:0] mem_addr,
  input wire logic [15:0] stack_ptr,
  input wire logic emu_mode
);
  addr_req_s r_q;
  logic [15:0] d_q;
  wire [15:0] bs = r_q.base + r_q.offset;
  wire pg = emu_flag && direct_reg[7:0] == 8'h00;
  wire [16:0] cs = {1'b0, r_q.base} + {1'b0, r_q.offset};
  wire [7:0] bk = WIDE_ADDR ? r_q.bank + {7'h00, cs[16]} : 8'h00;
  // Held copies keep the checks short
  always_ff @(posedge clk) begin
    r_q <= req;
    d_q <= direct_reg;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_stk; req.mode == mode_stack |=> mem_addr[23:16] == 8'h00; endproperty
  a_stk: assert property (p_stk) else $error("stack bank");
  property p_epg; emu_flag && req.mode == mode_stack |=> mem_addr[23:8] == 16'h0001; endproperty
  a_epg: assert property (p_epg) else $error("stack page");
  property p_mul; req.mode == mode_stack_multi |=> mem_addr == {8'h00, bs}; endproperty
  a_mul: assert property (p_mul) else $error("multi");
  property p_rel; req.mode == mode_stack_relative |=> mem_addr == {8'h00, bs}; endproperty
  a_rel: assert property (p_rel) else $error("relative");
  property p_dir; req.mode == mode_direct_long_ptr || req.mode == mode_direct && !pg |=>
    mem_addr == {8'h00, d_q + r_q.offset}; endproperty
  a_dir: assert property (p_dir) else $error("direct");
  property p_pg; pg && req.mode == mode_direct |=>
    mem_addr == {8'h00, d_q[15:8], r_q.offset[7:0]}; endproperty
  a_pg: assert property (p_pg) else $error("page");
  property p_abs; req.mode == mode_absolute_indexed |=> mem_addr[15:0] == bs; endproperty
  a_abs: assert property (p_abs) else $error("indexed");
  property p_emu; emu_flag |=> emu_mode && stack_ptr[15:8] == 8'h01; endproperty
  a_emu: assert property (p_emu) else $error("stack high");
  property p_bnk; req.mode == mode_absolute_indexed |=> mem_addr[23:16] == bk; endproperty
  a_bnk: assert property (p_bnk) else $error("indexed bank");
  property p_ld; !emu_flag && stack_load |=> stack_ptr == $past(stack_load_val); endproperty
  a_ld: assert property (p_ld) else $error("stack load");
endmodule : addr_range_wrap_props
bind addr_range_wrap addr_range_wrap_props #(.WIDE_ADDR(WIDE_ADDR))
  addr_range_wrap_props_inst(.clk, .rst_n, .emu_flag, .direct_reg, .stack_load,
  .stack_load_val, .req, .mem_addr, .stack_ptr, .emu_mode);

// File: verif/mem_model.sv
/* Memory stand-in on the address bus; assumes clk from the bench. */
`timescale 1ns/100ps
module mem_model(
  input wire logic clk,
  input wire logic [23:0] addr,
  output logic [7:0] data
);
  always_ff @(posedge clk) data <= addr[7:0] ^ addr[23:16];
endmodule : mem_model

// File: verif/tb.sv
/* Bench for addr_range_wrap; assumes the bound checker. */
`timescale 1ns/100ps
`include "addr_wrap_cfg.svh"
`define CK(n, e, s) begin checked++; if ((s) !== (e)) begin failures++; \
  $display("Error %s exp %h got %h", n, e, s); end end
module tb;
  import addr_wrap_pkg::*;
  logic clk = 0, rst_n = 0, emu_flag = 0, stack_load = 0, stack_step = 0, stack_down = 0;
  logic [15:0] direct_reg = '0, stack_load_val = '0, stack_ptr;
  logic [23:0] mem_addr;
  logic emu_mode;
  logic [7:0] mem_data;
  addr_req_s req = '0;
  int failures = 0, checked = 0;
  addr_range_wrap addr_range_wrap_inst(.clk, .rst_n, .emu_flag, .direct_reg, .stack_load,
    .stack_load_val, .stack_step, .stack_down, .req, .mem_addr, .stack_ptr, .emu_mode);
  mem_model mem_model_inst(.clk, .addr(mem_addr), .data(mem_data));
  initial forever #25 clk = ~clk;
  task chk(string n, logic e, logic [15:0] d, addr_mode_e m, logic [15:0] a, o, logic [23:0] x);
    @(negedge clk);
    {emu_flag, direct_reg, req} = {e, d, m, 8'h12, a, o};
    @(negedge clk);
    `CK(n, x, mem_addr)
  endtask : chk
  task t_reset;
    repeat (10) @(negedge clk);
    `CK("rst_addr", `ZERO_ADDR, mem_addr)
    `CK("rst_sp", `STACK_RESET_VAL, stack_ptr)
    `CK("rst_emu", `EMU_RESET_VAL, emu_mode)
    rst_n = 1;
  endtask : t_reset
  task t_sp;
    @(negedge clk);
    {emu_flag, stack_load, stack_load_val} = {1'b0, 1'b1, 16'h1234};
    @(negedge clk);
    `CK("nat_ld", 16'h1234, stack_ptr)
    {stack_load, stack_step, stack_down} = 3'b011;
    @(negedge clk);
    `CK("nat_dn", 16'h1233, stack_ptr)
    {emu_flag, stack_step} = 2'b10;
    @(negedge clk);
    `CK("emu_in", 16'h0133, stack_ptr)
    `CK("emu_md", 1'b1, emu_mode)
    {stack_load, stack_load_val} = {1'b1, 16'hABFF};
    @(negedge clk);
    `CK("emu_ld", 16'h01FF, stack_ptr)
    {stack_load, stack_step, stack_down} = 3'b010;
    @(negedge clk);
    `CK("emu_up", 16'h0100, stack_ptr)
    stack_step = 1'b0;
  endtask : t_sp
  task t_stack;
    chk("stk", 0, '0, mode_stack, 16'hABCD, '0, 24'h00_ABCD);
    chk("epg", 1, '0, mode_stack, 16'hABCD, '0, 24'h00_01CD);
    chk("mul", 1, '0, mode_stack_multi, 16'h01FF, 16'h0002, 24'h00_0201);
    chk("rel", 0, '0, mode_stack_relative, 16'hFFF0, 16'h0020, 24'h00_0010);
    chk("erel", 1, '0, mode_stack_relative, 16'h01F0, 16'h0020, 24'h00_0210);
  endtask : t_stack
  task t_dir;
    chk("nat", 0, 16'h1234, mode_direct, '0, 16'h00FF, 24'h00_1333);
    chk("pg", 1, 16'h1200, mode_direct, '0, 16'h0105, 24'h00_1205);
    chk("lp", 1, '0, mode_direct_long_ptr, '0, 16'h0100, 24'h00_0100);
    chk("zpg", 1, '0, mode_direct, '0, 16'h01FE, 24'h00_00FE);
    chk("full", 1, 16'h1201, mode_direct, '0, 16'h0105, 24'h00_1306);
    chk("abs", 0, '0, mode_absolute_indexed, 16'hFFF0, 16'h0020, 24'h13_0010);
  endtask : t_dir
  task t_long;
    chk("long", 0, '0, mode_long, 16'hFFF0, 16'h0020, 24'h13_0010);
    @(negedge clk);
    `CK("mem", 8'h03, mem_data)
  endtask : t_long
  task report_and_stop;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : report_and_stop
  initial begin
    t_reset();
    t_sp();
    t_stack();
    t_dir();
    t_long();
    report_and_stop();
  end
  // About five times the expected run of some 41 cycles
  initial begin
    repeat (200) @(posedge clk);
    failures++;
    report_and_stop();
  end
endmodule : tb
